// *** testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import uepc_pkg::*;
    logic clk, rst, pready, serr, pslverr, rv, txe, rdy, bv, txd, ack;
    logic rx_en, flush, flsb;
    logic [6:0] fa;
    logic [3:0] ep;
    logic [7:0] rb;
    logic [31:0] prdata, rd;
    logic [11:0] adr[4] = '{ADR_TXC1, ADR_EPC2, ADR_RXD1, ADR_RXS1};
    uepc_apb_req_type req;
    uepc_resp_type resp;
    uepc_token_type token;
    uepc_pkt_type pkt;
    int err_count = 0, total_checks = 0, seed = 32'h2d6d, n;
    uepc_top #(.DEPTH(16)) uut (.CLK(clk), .RST(rst), .APB_REQ(req),
        .PREADY(pready), .PSLVERR(pslverr), .PRDATA(prdata),
        .FUNC_ADDR(fa), .RX_ENABLE(rx_en), .RX_FLUSH(flush),
        .FRAME_LSB(flsb), .TOKEN(token), .RESP_VALID(rv), .RESP(resp),
        .TX_DONE(txd), .TX_ENABLED(txe), .RX_BYTE_VALID(bv),
        .RX_BYTE(rb), .RX_BYTE_READY(rdy), .RX_PKT(pkt), .ACK_SENT(ack));
    uepc_host_model hm (.clk(clk), .token(token), .tx_done(txd), .bv(bv),
        .rb(rb), .rdy(rdy), .pkt(pkt), .ack(ack));
    task automatic chk(input string nm, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rchk(input logic v, input uepc_resp_type r);
        #1;
        total_checks++;
        if ({rv, resp} !== {v, r}) begin
            err_count++;
            $display("BAD resp expected %h seen %h", {v, r}, {rv, resp});
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (!pready);
        rd = prdata;
        serr = pslverr;
        req <= '0;
    endtask
    function automatic logic [31:0] st(logic e, s, t, a, int c);
        return {24'h0, e, s, t, a, (c > 15) ? 4'hf : 4'(c)};
    endfunction
    task automatic rs(input logic [31:0] e);
        apb(1'b0, ADR_RXS1, 32'h0);
        chk("status", e, rd);
    endtask
    task automatic finish_test();
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        finish_test();
    end
    initial begin
        rst = 1'b1;
        {req, rx_en, flush, flsb} = '0;
        fa = 7'($random(seed));
        ep = 4'($random(seed));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        foreach (adr[i]) begin
            apb(1'b0, adr[i], 32'h0);
            chk("reset", 32'h0, rd);
        end
        apb(1'b1, ADR_EPC2, {28'h0, ep});
        hm.tok(TOK_IN, fa, ep);
        rchk(1'b0, RESP_NONE);
        apb(1'b1, ADR_EPC2, {28'h1, ep});
        apb(1'b0, ADR_EPC2, 32'h0);
        chk("epc", {28'h1, ep}, rd);
        hm.tok(TOK_IN, fa ^ 7'h1, ep);
        rchk(1'b0, RESP_NONE);
        hm.tok(TOK_IN, fa, ep ^ 4'h8);
        rchk(1'b0, RESP_NONE);
        hm.tok(TOK_IN, fa, ep);
        rchk(1'b1, RESP_NAK);
        apb(1'b1, ADR_TXC1, 32'h1);
        hm.tok(TOK_IN, fa, ep);
        rchk(1'b1, RESP_DATA);
        hm.done_tx();
        repeat (2) @(posedge clk);
        chk("txen", 32'h0, {31'h0, txe});
        apb(1'b1, ADR_EPC2, {28'h9, ep});
        apb(1'b1, ADR_TXC1, 32'h1);
        hm.tok(TOK_IN, fa, ep);
        rchk(1'b1, RESP_STALL);
        repeat (2) @(posedge clk);
        chk("txen", 32'h0, {31'h0, txe});
        rx_en <= 1'b1;
        hm.tok(TOK_OUT, fa, ep);
        rchk(1'b1, RESP_STALL);
        hm.tok(TOK_SETUP, fa, ep);
        rchk(1'b1, RESP_ACCEPT);
        rx_en <= 1'b0;
        apb(1'b1, ADR_EPC2, {28'h1, ep});
        for (int k = 0; k < 3; k++) begin
            n = (k == 0) ? 16 : 1 + ({$random(seed)} % 16);
            hm.send(n, '{1'b1, 1'b1, 1'b0, k == 2, k[0]}, 1'b1);
            if (k == 0) begin
                chk("rdy", 32'h0, {31'h0, rdy});
                hm.tok(TOK_SETUP, fa, ep);
                rchk(1'b1, RESP_NONE);
            end
            repeat (2) @(posedge clk);
            rs(st(1'b0, k == 2, k[0], 1'b1, n));
            rs(st(1'b0, 1'b0, 1'b0, 1'b0, n));
            repeat (n) begin
                apb(1'b0, ADR_RXD1, 32'h0);
                chk("byte", {24'h0, hm.sent_q.pop_front()}, rd);
            end
            rs(32'h0);
        end
        hm.send(2, '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0}, 1'b0);
        repeat (2) @(posedge clk);
        rs(st(1'b1, 1'b0, 1'b0, 1'b0, 2));
        flush <= 1'b1;
        @(posedge clk);
        flush <= 1'b0;
        hm.sent_q.delete();
        rs(32'h0);
        apb(1'b1, ADR_EPC2, {28'h3, ep});
        flsb <= 1'b1;
        hm.send(1, '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0}, 1'b0);
        repeat (2) @(posedge clk);
        rs(st(1'b0, 1'b0, 1'b1, 1'b0, 1));
        hm.tok(TOK_IN, fa, ep);
        rchk(1'b1, RESP_NONE);
        apb(1'b1, ADR_TSTC, 32'h1);
        apb(1'b1, ADR_RXD1, 32'h5a);
        chk("wr_err", 32'h0, {31'h0, serr});
        apb(1'b0, ADR_RXD1, 32'h0);
        chk("byte", {24'h0, hm.sent_q.pop_front()}, rd);
        apb(1'b0, ADR_RXD1, 32'h0);
        chk("tbyte", 32'h5a, rd);
        apb(1'b1, ADR_TSTC, 32'h0);
        apb(1'b1, ADR_RXD1, 32'h5a);
        chk("wr_err", 32'h1, {31'h0, serr});
        apb(1'b0, 12'h004, 32'h0);
        chk("unmapped", 32'h1, {31'h0, serr});
        finish_test();
    end
endmodule
`default_nettype wire

// *** uepc_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module uepc_host_model
    import uepc_pkg::*;
(
    // Clock
    input  wire logic                   clk,
    // Tokens and transmit progress
    output uepc_pkg::uepc_token_type    token,
    output logic                        tx_done,
    // Payload bytes and packet status
    output logic                        bv,
    output logic [uepc_pkg::BYTE_W-1:0] rb,
    input  wire logic                   rdy,
    output uepc_pkg::uepc_pkt_type      pkt,
    output logic                        ack
);
    logic [7:0] sent_q[$];
    int         seed = 32'h2d6d;
    initial begin
        token = '0;
        tx_done = 1'b0;
        bv = 1'b0;
        rb = 8'h00;
        pkt = '0;
        ack = 1'b0;
    end
    task automatic tok(input uepc_pid_type p, input logic [6:0] a,
                       input logic [3:0] e);
        @(posedge clk);
        token <= '{1'b1, p, a, e};
        @(posedge clk);
        token.valid <= 1'b0;
    endtask
    task automatic done_tx();
        @(posedge clk);
        tx_done <= 1'b1;
        @(posedge clk);
        tx_done <= 1'b0;
    endtask
    task automatic send(input int n, input uepc_pkt_type st,
                        input logic a);
        logic [7:0] b;
        for (int i = 0; i < n; i++) begin
            b = 8'($random(seed));
            @(posedge clk);
            bv <= 1'b1;
            rb <= b;
            do @(posedge clk); while (!rdy);
            sent_q.push_back(b);
            bv <= 1'b0;
            // Idle line shows the inverse so a stale byte cannot pass
            rb <= ~b;
        end
        @(posedge clk);
        pkt <= st;
        @(posedge clk);
        pkt.done <= 1'b0;
        ack <= a;
        @(posedge clk);
        ack <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** uepc_pkg.sv ***
// Operation
// - Hardware clears transmit enable after one packet sent or IN answered by STALL.
// - Halt bit stalls IN when transmit enabled, OUT when receive enabled.
// - SETUP tokens are never stalled by the halt bit.
// - Isochronous endpoint never answers NAK when enabled but not ready.
// - Enabled endpoint matches token endpoint number and function address.
// - Disabled endpoint ignores every token and gives no response.
// - Endpoint number is a four-bit read/write field, bits 3:0, reset zero.
// - Receive data port returns FIFO payload bytes only, in bits 7:0.
// - Receive data port is writable in test mode, read-only otherwise.
// - Receive error flag, bit 7, sets on media error of a packet.
// - Control packet flag, bit 6, sets on setup packet, read clears it.
// - Non-isochronous receive toggle bit 5 shows last good data PID.
// - Isochronous receive toggle captures frame number LSB on good packet.
// - Reading receive status resets the receive toggle bit to zero.
// - Receive acked flag, bit 4, sets after ACK sent, read clears it.
// - Receive byte count, bits 3:0, shows FIFO fill, saturating at 15.
package uepc_pkg;

    // Printed offsets are register indices; byte address is four times each
    localparam logic [31:0] IDX_TXC1 = 32'h50001856;
    localparam logic [31:0] IDX_EPC2 = 32'h50001858;
    localparam logic [31:0] IDX_RXD1 = 32'h5000185a;
    localparam logic [31:0] IDX_RXS1 = 32'h5000185c;
    localparam logic [31:0] IDX_TSTC = 32'h50001870;
    localparam int          ADDR_W   = 12;

    function automatic logic [ADDR_W-1:0] uepc_byte_addr(
        input logic [31:0] idx);
        return {idx[ADDR_W-3:0], 2'b00};
    endfunction

    localparam logic [ADDR_W-1:0] ADR_TXC1 = uepc_byte_addr(IDX_TXC1);
    localparam logic [ADDR_W-1:0] ADR_EPC2 = uepc_byte_addr(IDX_EPC2);
    localparam logic [ADDR_W-1:0] ADR_RXD1 = uepc_byte_addr(IDX_RXD1);
    localparam logic [ADDR_W-1:0] ADR_RXS1 = uepc_byte_addr(IDX_RXS1);
    localparam logic [ADDR_W-1:0] ADR_TSTC = uepc_byte_addr(IDX_TSTC);

    // Field positions
    localparam int BIT_TX_EN   = 0;
    localparam int BIT_STALL   = 7;
    localparam int BIT_ISO     = 5;
    localparam int BIT_EP_EN   = 4;
    localparam int BIT_RX_ERR  = 7;
    localparam int BIT_SETUP   = 6;
    localparam int BIT_TOGGLE  = 5;
    localparam int BIT_RX_LAST = 4;
    localparam int BIT_TEST    = 0;
    localparam int EPNUM_W     = 4;
    localparam int COUNT_W     = 4;
    localparam int BYTE_W      = 8;
    localparam int FADDR_W     = 7;

    localparam logic [COUNT_W-1:0] COUNT_MAX = 4'hf;
    localparam logic [EPNUM_W-1:0] EPNUM_RST = 4'h0;
    localparam logic               FLAG_RST  = 1'b0;
    localparam int                 FIFO_DEPTH = 64;

    typedef enum logic [1:0] {
        TOK_OUT,
        TOK_IN,
        TOK_SETUP
    } uepc_pid_type;

    typedef enum logic [2:0] {
        RESP_NONE,
        RESP_NAK,
        RESP_STALL,
        RESP_DATA,
        RESP_ACCEPT
    } uepc_resp_type;

    typedef enum logic {
        TXS_IDLE,
        TXS_SEND
    } uepc_txst_type;

    typedef struct packed {
        logic               valid;
        uepc_pid_type       pid;
        logic [FADDR_W-1:0] addr;
        logic [EPNUM_W-1:0] ep;
    } uepc_token_type;

    typedef struct packed {
        logic done;
        logic ok;
        logic media_err;
        logic setup;
        logic data1;
    } uepc_pkt_type;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } uepc_apb_req_type;

endpackage

// *** uepc_rx_fifo.sv ***
`timescale 1ns/1ns
`default_nettype none
module uepc_rx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64,
    parameter int AW    = $clog2(DEPTH),
    parameter int CW    = $clog2(DEPTH + 1)
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Flush
    input  wire logic             flush,
    // Fill side
    input  wire logic             push_valid,
    input  wire logic [WIDTH-1:0] push_data,
    output logic                  push_ready,
    // Drain side
    input  wire logic             pop_ready,
    output logic                  pop_valid,
    output logic      [WIDTH-1:0] pop_data,
    output logic      [CW-1:0]    count
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [CW-1:0]               cnt;
    } uepc_fifo_st_type;

    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

    uepc_fifo_st_type st_r;
    uepc_fifo_st_type st_nxt;
    logic             do_push;
    logic             do_pop;

    assign push_ready = (st_r.cnt != CNT_FULL);
    assign pop_valid  = (st_r.cnt != '0);
    assign pop_data   = st_r.mem[st_r.rp];
    assign count      = st_r.cnt;
    assign do_push    = push_valid && push_ready;
    assign do_pop     = pop_ready && pop_valid;

    always_comb begin
        st_nxt = st_r;
        if (do_push) begin
            st_nxt.mem[st_r.wp] = push_data;
            st_nxt.wp = (st_r.wp == PTR_LAST) ? '0 : st_r.wp + 1'b1;
        end
        if (do_pop) begin
            st_nxt.rp = (st_r.rp == PTR_LAST) ? '0 : st_r.rp + 1'b1;
        end
        case ({do_push, do_pop})
            2'b10:   st_nxt.cnt = st_r.cnt + 1'b1;
            2'b01:   st_nxt.cnt = st_r.cnt - 1'b1;
            default: st_nxt.cnt = st_r.cnt;
        endcase
        // Flush drops everything, including a same-cycle push
        if (flush) begin
            st_nxt.wp  = '0;
            st_nxt.rp  = '0;
            st_nxt.cnt = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule
`default_nettype wire

// *** uepc_top.sv ***
// The APB register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module uepc_top
    import uepc_pkg::*;
#(
    parameter int DEPTH = uepc_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                        CLK,
    input  wire logic                        RST,
    // APB slave
    input  wire uepc_pkg::uepc_apb_req_type  APB_REQ,
    output logic                             PREADY,
    output logic                             PSLVERR,
    output logic [31:0]                      PRDATA,
    // Context from neighbouring registers and frame counter
    input  wire logic [uepc_pkg::FADDR_W-1:0] FUNC_ADDR,
    input  wire logic                        RX_ENABLE,
    input  wire logic                        RX_FLUSH,
    input  wire logic                        FRAME_LSB,
    // Token from serial engine and handshake decision
    input  wire uepc_pkg::uepc_token_type    TOKEN,
    output logic                             RESP_VALID,
    output uepc_pkg::uepc_resp_type          RESP,
    // Transmit progress from serial engine
    input  wire logic                        TX_DONE,
    output logic                             TX_ENABLED,
    // Receive payload bytes and packet status from serial engine
    input  wire logic                        RX_BYTE_VALID,
    input  wire logic [uepc_pkg::BYTE_W-1:0] RX_BYTE,
    output logic                             RX_BYTE_READY,
    input  wire uepc_pkg::uepc_pkt_type      RX_PKT,
    input  wire logic                        ACK_SENT
);
    import uepc_pkg::*;

    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic               tx_en;
        uepc_txst_type      txst;
        logic               stall;
        logic               iso;
        logic               ep_en;
        logic [EPNUM_W-1:0] ep_num;
        logic               test_mode;
        logic               rx_err;
        logic               setup;
        logic               toggle;
        logic               rx_last;
        logic [31:0]        rdata;
        logic               resp_valid;
        uepc_resp_type      resp;
    } uepc_state_type;

    uepc_state_type      st_r;
    uepc_state_type      st_nxt;
    logic                setup_ph;
    logic                access_ph;
    logic                wr_acc;
    logic                rd_acc;
    logic                unmapped;
    logic                test_push;
    logic                fifo_push;
    logic [BYTE_W-1:0]   fifo_din;
    logic                fifo_ready;
    logic                fifo_pop;
    logic                fifo_valid;
    logic [BYTE_W-1:0]   fifo_head;
    logic [CW-1:0]       fifo_cnt;
    logic [COUNT_W-1:0]  rcount;
    logic                tok_hit;
    logic                pkt_good;

    function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] r);
        return a == r;
    endfunction

    // Bus phases; access completes with no wait state
    assign setup_ph  = APB_REQ.psel && !APB_REQ.penable;
    assign access_ph = APB_REQ.psel && APB_REQ.penable;
    assign wr_acc    = access_ph && APB_REQ.pwrite;
    assign rd_acc    = access_ph && !APB_REQ.pwrite;
    assign unmapped  = !(addr_is(APB_REQ.paddr, ADR_TXC1) ||
                         addr_is(APB_REQ.paddr, ADR_EPC2) ||
                         addr_is(APB_REQ.paddr, ADR_RXD1) ||
                         addr_is(APB_REQ.paddr, ADR_RXS1) ||
                         addr_is(APB_REQ.paddr, ADR_TSTC));
    assign PREADY    = access_ph;
    // data port write only in test mode
    assign PSLVERR   = access_ph && (unmapped ||
                       (APB_REQ.pwrite && !st_r.test_mode &&
                        addr_is(APB_REQ.paddr, ADR_RXD1)));
    assign PRDATA    = st_r.rdata;

    // test mode write pushes the FIFO, engine stalls that cycle
    assign test_push = wr_acc && st_r.test_mode &&
                       addr_is(APB_REQ.paddr, ADR_RXD1);
    assign fifo_push = test_push || RX_BYTE_VALID;
    assign fifo_din  = test_push ? APB_REQ.pwdata[BYTE_W-1:0] : RX_BYTE;
    assign RX_BYTE_READY = fifo_ready && !test_push;
    // a data port read consumes the head byte
    assign fifo_pop  = rd_acc && addr_is(APB_REQ.paddr, ADR_RXD1);

    uepc_rx_fifo #(
        .WIDTH (BYTE_W),
        .DEPTH (DEPTH)
    ) u_rx_fifo (
        .clk        (CLK),
        .rst        (RST),
        .flush      (RX_FLUSH),
        .push_valid (fifo_push),
        .push_data  (fifo_din),
        .push_ready (fifo_ready),
        .pop_ready  (fifo_pop),
        .pop_valid  (fifo_valid),
        .pop_data   (fifo_head),
        .count      (fifo_cnt)
    );

    assign rcount = (fifo_cnt > CW'(COUNT_MAX)) ? COUNT_MAX
                                                : fifo_cnt[COUNT_W-1:0];

    // token matches endpoint number and function address
    assign tok_hit  = TOKEN.valid && st_r.ep_en &&
                      (TOKEN.addr == FUNC_ADDR) &&
                      (TOKEN.ep == st_r.ep_num);
    assign pkt_good = RX_PKT.done && RX_PKT.ok;

    assign RESP_VALID = st_r.resp_valid;
    assign RESP       = st_r.resp;
    assign TX_ENABLED = st_r.tx_en;

    always_comb begin
        st_nxt = st_r;
        st_nxt.resp_valid = 1'b0;
        st_nxt.resp = RESP_NONE;

        // Read data is captured in setup so the access edge can clear
        // flags without losing what was returned
        if (setup_ph && !APB_REQ.pwrite) begin
            st_nxt.rdata = '0;
            if (addr_is(APB_REQ.paddr, ADR_TXC1)) begin
                st_nxt.rdata[BIT_TX_EN] = st_r.tx_en;
            end
            if (addr_is(APB_REQ.paddr, ADR_EPC2)) begin
                st_nxt.rdata[BIT_STALL] = st_r.stall;
                st_nxt.rdata[BIT_ISO] = st_r.iso;
                st_nxt.rdata[BIT_EP_EN] = st_r.ep_en;
                st_nxt.rdata[EPNUM_W-1:0] = st_r.ep_num;
            end
            // payload byte in low bits, upper bits zero
            if (addr_is(APB_REQ.paddr, ADR_RXD1)) begin
                st_nxt.rdata[BYTE_W-1:0] = fifo_valid ? fifo_head : '0;
            end
            if (addr_is(APB_REQ.paddr, ADR_RXS1)) begin
                st_nxt.rdata[BIT_RX_ERR] = st_r.rx_err;
                st_nxt.rdata[BIT_SETUP] = st_r.setup;
                st_nxt.rdata[BIT_TOGGLE] = st_r.toggle;
                st_nxt.rdata[BIT_RX_LAST] = st_r.rx_last;
                st_nxt.rdata[COUNT_W-1:0] = rcount;
            end
            if (addr_is(APB_REQ.paddr, ADR_TSTC)) begin
                st_nxt.rdata[BIT_TEST] = st_r.test_mode;
            end
        end

        // status read clears only after the value was returned
        if (rd_acc && addr_is(APB_REQ.paddr, ADR_RXS1)) begin
            st_nxt.setup = st_r.setup & ~st_r.rdata[BIT_SETUP];
            st_nxt.rx_last = st_r.rx_last & ~st_r.rdata[BIT_RX_LAST];
            st_nxt.toggle = 1'b0;
            // Error flag stays until firmware has flushed
            if (RX_FLUSH) begin
                st_nxt.rx_err = 1'b0;
            end
        end else if (RX_FLUSH) begin
            st_nxt.rx_err = 1'b0;
        end

        // Writes of control registers
        if (wr_acc && addr_is(APB_REQ.paddr, ADR_EPC2)) begin
            st_nxt.stall = APB_REQ.pwdata[BIT_STALL];
            st_nxt.iso = APB_REQ.pwdata[BIT_ISO];
            st_nxt.ep_en = APB_REQ.pwdata[BIT_EP_EN];
            st_nxt.ep_num = APB_REQ.pwdata[EPNUM_W-1:0];
        end
        if (wr_acc && addr_is(APB_REQ.paddr, ADR_TSTC)) begin
            st_nxt.test_mode = APB_REQ.pwdata[BIT_TEST];
        end

        // Transmit side: packet completion ends the send phase
        case (st_r.txst)
            TXS_IDLE: begin
                st_nxt.txst = TXS_IDLE;
            end
            TXS_SEND: begin
                if (TX_DONE) begin
                    st_nxt.txst = TXS_IDLE;
                    // one packet sent clears transmit enable
                    st_nxt.tx_en = 1'b0;
                end
            end
            default: begin
                st_nxt.txst = TXS_IDLE;
            end
        endcase

        // Handshake decision for a matching token
        if (tok_hit) begin
            st_nxt.resp_valid = 1'b1;
            case (TOKEN.pid)
                TOK_IN: begin
                    // halt stalls IN when transmit enabled
                    if (st_r.stall && st_r.tx_en) begin
                        st_nxt.resp = RESP_STALL;
                        // STALL on IN clears transmit enable
                        st_nxt.tx_en = 1'b0;
                    // data only goes out while enabled
                    end else if (st_r.tx_en && st_r.txst == TXS_IDLE) begin
                        st_nxt.resp = RESP_DATA;
                        st_nxt.txst = TXS_SEND;
                    end else if (st_r.iso) begin
                        st_nxt.resp = RESP_NONE;
                    end else begin
                        st_nxt.resp = RESP_NAK;
                    end
                end
                TOK_OUT: begin
                    // halt stalls OUT when receive enabled
                    if (st_r.stall && RX_ENABLE) begin
                        st_nxt.resp = RESP_STALL;
                    end else if (RX_ENABLE && fifo_ready) begin
                        st_nxt.resp = RESP_ACCEPT;
                    end else if (st_r.iso) begin
                        st_nxt.resp = RESP_NONE;
                    end else begin
                        st_nxt.resp = RESP_NAK;
                    end
                end
                TOK_SETUP: begin
                    st_nxt.resp = fifo_ready ? RESP_ACCEPT : RESP_NONE;
                end
                default: begin
                    st_nxt.resp = RESP_NONE;
                end
            endcase
        end

        // Software sets transmit enable; a write wins over a clear
        if (wr_acc && addr_is(APB_REQ.paddr, ADR_TXC1)) begin
            st_nxt.tx_en = APB_REQ.pwdata[BIT_TX_EN];
        end

        // Packet events win over same-cycle read clears
        // media error sets error flag
        if (RX_PKT.done && RX_PKT.media_err) begin
            st_nxt.rx_err = 1'b1;
        end
        if (pkt_good) begin
            if (RX_PKT.setup) begin
                st_nxt.setup = 1'b1;
            end
            // isochronous toggle takes frame number LSB
            st_nxt.toggle = st_r.iso ? FRAME_LSB : RX_PKT.data1;
        end
        if (ACK_SENT) begin
            st_nxt.rx_last = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            st_r <= '{tx_en: FLAG_RST, txst: TXS_IDLE, stall: FLAG_RST,
                      iso: FLAG_RST, ep_en: FLAG_RST, ep_num: EPNUM_RST,
                      test_mode: FLAG_RST, rx_err: FLAG_RST,
                      setup: FLAG_RST, toggle: FLAG_RST,
                      rx_last: FLAG_RST, rdata: '0,
                      resp_valid: FLAG_RST, resp: RESP_NONE};
        end else begin
            st_r <= st_nxt;
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    sequence stall_in_s;
        tok_hit && TOKEN.pid == TOK_IN && st_r.stall && st_r.tx_en &&
        !wr_acc;
    endsequence

    sequence rxs_read_s;
        setup_ph && !APB_REQ.pwrite &&
        addr_is(APB_REQ.paddr, ADR_RXS1) ##1 rd_acc;
    endsequence

    tx_en_done_a: assert property (
        st_r.txst == TXS_SEND && TX_DONE && !wr_acc |=> !st_r.tx_en)
        else $error("Transmit enable not cleared after packet");

    stall_in_a: assert property (
        stall_in_s |=> RESP_VALID && RESP == RESP_STALL && !TX_ENABLED)
        else $error("IN token not stalled or enable kept");

    setup_no_stall_a: assert property (
        tok_hit && TOKEN.pid == TOK_SETUP |=> RESP != RESP_STALL)
        else $error("SETUP token answered with STALL");

    iso_no_nak_a: assert property (
        tok_hit && st_r.iso |=> RESP != RESP_NAK)
        else $error("Isochronous endpoint sent NAK");

    ep_match_a: assert property (
        TOKEN.valid && st_r.ep_en && TOKEN.addr == FUNC_ADDR &&
        TOKEN.ep == st_r.ep_num |=> RESP_VALID)
        else $error("Matching token got no decision");

    disabled_quiet_a: assert property (
        !st_r.ep_en |=> !RESP_VALID)
        else $error("Disabled endpoint responded");

    ro_port_a: assert property (
        wr_acc && !st_r.test_mode && addr_is(APB_REQ.paddr, ADR_RXD1)
        |-> PSLVERR && !test_push)
        else $error("Data port written outside test mode");

    rx_err_set_a: assert property (
        RX_PKT.done && RX_PKT.media_err |=> st_r.rx_err)
        else $error("Receive error flag not set");

    setup_clear_a: assert property (
        rxs_read_s ##0 (PRDATA[BIT_SETUP] && !(pkt_good && RX_PKT.setup))
        |=> !st_r.setup)
        else $error("Control flag not cleared by read");

    toggle_iso_a: assert property (
        pkt_good && st_r.iso |=> st_r.toggle == $past(FRAME_LSB))
        else $error("Isochronous toggle missed frame LSB");

    acked_set_a: assert property (
        ACK_SENT |=> st_r.rx_last ##1 (st_r.rx_last || $past(rd_acc)))
        else $error("Acked flag not set");

    count_sat_a: assert property (
        setup_ph && !APB_REQ.pwrite && addr_is(APB_REQ.paddr, ADR_RXS1) &&
        fifo_cnt >= CW'(COUNT_MAX) |=> PRDATA[COUNT_W-1:0] == COUNT_MAX)
        else $error("Byte count not saturated");

    read_prev_a: assert property (
        setup_ph && !APB_REQ.pwrite && addr_is(APB_REQ.paddr, ADR_RXS1)
        |=> PRDATA[BIT_SETUP] == $past(st_r.setup))
        else $error("Status read lost pre-read value");
endmodule
`default_nettype wire
